// ### hdl/spisd_core.sv
// byte-wide serial port: status flags, data path, master sequencer and bus slave
`timescale 1ns/1ps
`default_nettype none
`include "spisd_defs.svh"

module spisd_core #(
    parameter int ADDR_W = 4
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // wishbone classic slave
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [ADDR_W-1:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    // serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // master-out data pin
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe,
    // master-in data pin
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe,
    // slave select, active low
    input wire logic ss_n,
    // interrupt request
    output logic irq
);

    // offsets need four address bits
    if (ADDR_W < 4) begin : g_chk
        $error("spisd_core: ADDR_W must be at least 4");
    end

    // synchronised pins
    logic [3:0] pins_s;
    spisd_sync #(.WIDTH(4)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .clk_en(clk_en),
        .din({ss_n, miso_in, mosi_in, sck_in}),
        .dout(pins_s)
    );
    wire sck_s = pins_s[0];
    wire mosi_s = pins_s[1];
    wire miso_s = pins_s[2];
    wire ss_n_s = pins_s[3];

    // state
    logic [7:0] ctrl; // control register
    logic transfer_done_flag, write_collision_flag, mode_fault_flag; // status flags
    logic transfer_done_flag_armed, write_collision_flag_armed, mode_fault_flag_armed; // first half of clear sequences seen
    logic write_lock; // data writes blocked after a transfer
    spisd_pkg::spisd_byte_t sr; // shift register
    spisd_pkg::spisd_byte_t rx_buf; // receive buffer
    logic out_bit; // bit on the data output pin
    spisd_pkg::spisd_state_e mst_state; // master sequencer
    logic [4:0] half_cnt; // cycles left in this half period
    logic [4:0] edge_cnt; // serial clock edges so far
    logic sck_level; // master serial clock level
    logic sck_prev; // last synchronised serial clock
    logic slv_active; // slave transfer in progress
    logic [2:0] bit_cnt; // slave samples so far

    // control fields
    wire irq_enable_bit = ctrl[`SPISD_B_IRQEN];
    wire pen = ctrl[`SPISD_B_PEN];
    wire master_select_bit = ctrl[`SPISD_B_MASTER_SELECT_BIT];
    wire cpol = ctrl[`SPISD_B_CPOL];
    wire clock_phase_bit = ctrl[`SPISD_B_CLOCK_PHASE_BIT];
    wire [1:0] rate = ctrl[`SPISD_B_RATE_HI:`SPISD_B_RATE_LO];

    // bus decode; one access per request, ack blocks a repeat
    wire acc = clk_en & wb_cyc & wb_stb & ~wb_ack;
    wire hit_c = (wb_adr == ADDR_W'(`SPISD_OFS_CTRL));
    wire hit_s = (wb_adr == ADDR_W'(`SPISD_OFS_STAT));
    wire hit_d = (wb_adr == ADDR_W'(`SPISD_OFS_DATA));
    wire wr_lane0 = wb_we & wb_sel[0];
    wire wr_ctrl = acc & hit_c & wr_lane0;
    wire rd_stat = acc & hit_s & ~wb_we;
    wire acc_data = acc & hit_d;
    wire wr_data = acc_data & wr_lane0;

    // transfer in progress, either role
    wire busy = (mst_state == spisd_pkg::SPISD_SHIFT) | slv_active;
    // write while busy collides and is dropped
    wire col_wr = wr_data & busy;
    // accepted write goes straight into the shift register
    wire load_ok = wr_data & ~busy & ~write_lock;
    // master sees its select pulled low
    wire mode_fault_flag_hit = clk_en & pen & master_select_bit & ~ss_n_s;
    // only an enabled master launches an exchange
    wire start = load_ok & pen & master_select_bit & ~mode_fault_flag_hit;

    // master half period from the rate field
    wire [4:0] half_load = (rate == 2'h0) ? `SPISD_HALF_DIV2 :
                           (rate == 2'h1) ? `SPISD_HALF_DIV4 :
                           (rate == 2'h2) ? `SPISD_HALF_DIV16 : `SPISD_HALF_DIV32;

    // master clock edges: even count is leading, odd trailing
    wire m_tick = clk_en & (mst_state == spisd_pkg::SPISD_SHIFT) & (half_cnt == 5'h00)
                  & ~mode_fault_flag_hit;
    wire m_lead = m_tick & ~edge_cnt[0];
    wire m_trail = m_tick & edge_cnt[0];
    wire m_done = m_tick & (edge_cnt == `SPISD_LAST_EDGE);

    // slave edges from the synchronised pin clock
    wire slave_sel = pen & ~master_select_bit & ~ss_n_s;
    wire sck_rise = sck_s & ~sck_prev;
    wire sck_fall = ~sck_s & sck_prev;
    wire s_lead = clk_en & slave_sel & (cpol ? sck_fall : sck_rise);
    wire s_trail = clk_en & slave_sel & (cpol ? sck_rise : sck_fall);

    // phase picks which edge samples and which drives
    wire e_lead = m_lead | s_lead;
    wire e_trail = m_trail | s_trail;
    wire sample_e = clock_phase_bit ? e_trail : e_lead;
    wire drive_e = clock_phase_bit ? e_lead : e_trail;
    wire s_done = sample_e & slv_active & ~master_select_bit & (bit_cnt == `SPISD_LAST_BIT);
    wire done = m_done | s_done;

    // incoming bit and shifted value
    wire in_bit = master_select_bit ? miso_s : mosi_s;
    wire [7:0] next_sr = {sr[6:0], in_bit};
    // byte as it stands once the last sample is in
    wire [7:0] rx_val = sample_e ? next_sr : sr;

    // status byte, unused bits zero
    wire [7:0] stat_val = (8'(transfer_done_flag) << `SPISD_B_TRANSFER_DONE_FLAG) | (8'(write_collision_flag) << `SPISD_B_WRITE_COLLISION_FLAG)
                        | (8'(mode_fault_flag) << `SPISD_B_MODE_FAULT_FLAG);
    wire [7:0] rd_val = hit_c ? ctrl : hit_s ? stat_val : hit_d ? rx_buf : 8'h00;

    // bus answer: ack one cycle after the request, unmapped reads zero
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            wb_ack <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else if (clk_en) begin
            wb_ack <= acc;
            if (acc & ~wb_we) begin
                wb_dat_r <= {24'h00_0000, rd_val};
            end
        end
    end

    // control register; mode fault beats a same-cycle write
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl <= `SPISD_CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= wb_dat_w[7:0];
            end
            if (mode_fault_flag_hit) begin
                ctrl[`SPISD_B_PEN] <= 1'b0;
                ctrl[`SPISD_B_MASTER_SELECT_BIT] <= 1'b0;
            end
        end
    end

    // transfer done flag and its clear sequence; set wins over clear
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            transfer_done_flag <= 1'b0;
            transfer_done_flag_armed <= 1'b0;
            write_lock <= 1'b0;
        end else if (clk_en) begin
            if (done) begin
                transfer_done_flag <= 1'b1;
            end else if (acc_data & transfer_done_flag_armed) begin
                transfer_done_flag <= 1'b0;
            end
            if (acc_data & transfer_done_flag_armed) begin
                transfer_done_flag_armed <= 1'b0;
            end else if (rd_stat & transfer_done_flag) begin
                transfer_done_flag_armed <= 1'b1;
            end
            if (done) begin
                write_lock <= 1'b1;
            end else if (rd_stat & transfer_done_flag) begin
                write_lock <= 1'b0;
            end
        end
    end

    // write collision flag and its clear sequence
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            write_collision_flag <= 1'b0;
            write_collision_flag_armed <= 1'b0;
        end else if (clk_en) begin
            if (col_wr) begin
                write_collision_flag <= 1'b1;
            end else if (acc_data & write_collision_flag_armed) begin
                write_collision_flag <= 1'b0;
            end
            if (acc_data & write_collision_flag_armed) begin
                write_collision_flag_armed <= 1'b0;
            end else if (rd_stat & write_collision_flag) begin
                write_collision_flag_armed <= 1'b1;
            end
        end
    end

    // mode fault flag; cleared by a control write after an armed read
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mode_fault_flag <= 1'b0;
            mode_fault_flag_armed <= 1'b0;
        end else if (clk_en) begin
            if (mode_fault_flag_hit) begin
                mode_fault_flag <= 1'b1;
            end else if (wr_ctrl & mode_fault_flag_armed) begin
                mode_fault_flag <= 1'b0;
            end
            if (wr_ctrl & mode_fault_flag_armed) begin
                mode_fault_flag_armed <= 1'b0;
            end else if (rd_stat & mode_fault_flag) begin
                mode_fault_flag_armed <= 1'b1;
            end
        end
    end

    // shift register and receive buffer; an overrun byte never reaches the buffer
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sr <= 8'h00;
            rx_buf <= 8'h00;
        end else if (clk_en) begin
            if (load_ok) begin
                sr <= wb_dat_w[7:0];
            end else if (sample_e) begin
                sr <= next_sr;
            end
            if (done & ~transfer_done_flag) begin
                rx_buf <= rx_val;
            end
        end
    end

    // output bit: loaded with the msb, then advanced on driving edges
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            out_bit <= 1'b0;
        end else if (clk_en) begin
            if (load_ok) begin
                out_bit <= wb_dat_w[7];
            end else if (drive_e | ~busy) begin
                out_bit <= sr[7];
            end
        end
    end

    // master sequencer: sixteen half periods per byte, abort on mode fault
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mst_state <= spisd_pkg::SPISD_IDLE;
            half_cnt <= 5'h00;
            edge_cnt <= 5'h00;
            sck_level <= 1'b0;
        end else if (clk_en) begin
            unique case (mst_state)
                spisd_pkg::SPISD_IDLE: begin
                    sck_level <= cpol; // idle level follows polarity
                    if (start) begin
                        mst_state <= spisd_pkg::SPISD_SHIFT;
                        half_cnt <= half_load - 5'h01;
                        edge_cnt <= 5'h00;
                    end
                end
                spisd_pkg::SPISD_SHIFT: begin
                    if (mode_fault_flag_hit) begin
                        mst_state <= spisd_pkg::SPISD_IDLE;
                        sck_level <= cpol;
                    end else if (half_cnt == 5'h00) begin
                        sck_level <= ~sck_level;
                        edge_cnt <= edge_cnt + 5'h01;
                        half_cnt <= half_load - 5'h01;
                        if (m_done) begin
                            mst_state <= spisd_pkg::SPISD_IDLE;
                        end
                    end else begin
                        half_cnt <= half_cnt - 5'h01;
                    end
                end
            endcase
        end
    end

    // slave transfer window; phase 0 spans the whole select low time
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            slv_active <= 1'b0;
            bit_cnt <= 3'h0;
            sck_prev <= 1'b0;
        end else if (clk_en) begin
            sck_prev <= sck_s;
            if (~slave_sel) begin
                slv_active <= 1'b0;
                bit_cnt <= 3'h0;
            end else begin
                if (~clock_phase_bit) begin
                    slv_active <= 1'b1;
                end else if (s_lead & ~slv_active) begin
                    slv_active <= 1'b1;
                end else if (s_done) begin
                    slv_active <= 1'b0;
                end
                if (sample_e & slv_active) begin
                    bit_cnt <= bit_cnt + 3'h1; // wraps for back-to-back bytes
                end
            end
        end
    end

    // pin drivers and interrupt, all registered
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sck_out <= 1'b0;
            sck_oe <= 1'b0;
            mosi_out <= 1'b0;
            mosi_oe <= 1'b0;
            miso_out <= 1'b0;
            miso_oe <= 1'b0;
            irq <= 1'b0;
        end else if (clk_en) begin
            sck_out <= sck_level;
            sck_oe <= pen & master_select_bit;
            mosi_out <= out_bit;
            mosi_oe <= pen & master_select_bit;
            miso_out <= out_bit;
            miso_oe <= slave_sel;
            irq <= irq_enable_bit & (transfer_done_flag | mode_fault_flag);
        end
    end

    // status read shows zero in unused bits
    status_zero_a: assert property (@(posedge core_clk) disable iff (reset)
        (rd_stat ##1 wb_ack) |-> (wb_dat_r[5] == 1'b0 && wb_dat_r[3:0] == 4'h0))
        else $error("unused status bits not zero");

    // finished byte raises the done flag
    done_sets_a: assert property (@(posedge core_clk) disable iff (reset)
        done |=> transfer_done_flag)
        else $error("done flag missing after transfer");

    // enabled done flag requests an interrupt
    done_irq_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && $rose(transfer_done_flag) && irq_enable_bit) |=> irq)
        else $error("no interrupt on done flag");

    // done flag survives a data access without a prior status read
    done_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        (transfer_done_flag && !transfer_done_flag_armed && acc_data) |=> transfer_done_flag)
        else $error("done flag cleared without status read");

    // locked data write leaves the shift register alone
    write_lock_a: assert property (@(posedge core_clk) disable iff (reset)
        (wr_data && write_lock && !busy && !sample_e) |=> (sr == $past(sr)))
        else $error("locked data write was accepted");

    // colliding write flags and keeps the master running
    collision_a: assert property (@(posedge core_clk) disable iff (reset)
        (col_wr && mst_state == spisd_pkg::SPISD_SHIFT && !m_done && !mode_fault_flag_hit)
        |=> (write_collision_flag && mst_state == spisd_pkg::SPISD_SHIFT && edge_cnt >= $past(edge_cnt)))
        else $error("collision mishandled");

    // mode fault drops master and enable and sets the flag
    mode_fault_a: assert property (@(posedge core_clk) disable iff (reset)
        mode_fault_flag_hit |=> (mode_fault_flag && !pen && !master_select_bit ##1 !mosi_oe))
        else $error("mode fault effects missing");

    // mode fault survives a control write without a prior status read
    fault_hold_a: assert property (@(posedge core_clk) disable iff (reset)
        (mode_fault_flag && !mode_fault_flag_armed && wr_ctrl) |=> mode_fault_flag)
        else $error("mode fault cleared without status read");

    // overrun keeps the old receive byte
    overrun_a: assert property (@(posedge core_clk) disable iff (reset)
        (done && transfer_done_flag) |=> $stable(rx_buf))
        else $error("overrun byte overwrote buffer");

    // only an enabled master starts the sequencer
    master_start_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && mst_state == spisd_pkg::SPISD_IDLE && $past(mst_state) ==
         spisd_pkg::SPISD_IDLE ##1 mst_state == spisd_pkg::SPISD_SHIFT)
        |-> $past(wr_data && pen && master_select_bit))
        else $error("exchange started without master write");

endmodule : spisd_core

`default_nettype wire

// ### include/spisd_defs.svh
// register map, field positions, reset values and timing counts of the serial port
`ifndef SPISD_DEFS_SVH
`define SPISD_DEFS_SVH

// byte offsets of the three registers on the bus
`define SPISD_OFS_CTRL 4'h0
`define SPISD_OFS_STAT 4'h4
`define SPISD_OFS_DATA 4'h8

// control register layout and reset value
`define SPISD_CTRL_RST 8'h04
`define SPISD_B_IRQEN 7
`define SPISD_B_PEN 6
`define SPISD_B_MASTER_SELECT_BIT 4
`define SPISD_B_CPOL 3
`define SPISD_B_CLOCK_PHASE_BIT 2
`define SPISD_B_RATE_HI 1
`define SPISD_B_RATE_LO 0

// status register layout
`define SPISD_B_TRANSFER_DONE_FLAG 7
`define SPISD_B_WRITE_COLLISION_FLAG 6
`define SPISD_B_MODE_FAULT_FLAG 4

// half periods of the master serial clock, in core clock cycles
`define SPISD_HALF_DIV2 5'h01
`define SPISD_HALF_DIV4 5'h02
`define SPISD_HALF_DIV16 5'h08
`define SPISD_HALF_DIV32 5'h10

// index of the last serial clock edge and of the last sample in one byte
`define SPISD_LAST_EDGE 5'h0f
`define SPISD_LAST_BIT 3'h7

`endif

// ### include/spisd_pkg.sv
// types shared by the serial port design
package spisd_pkg;

    // master shift sequencer states
    typedef enum logic [0:0] {
        SPISD_IDLE = 1'b0,
        SPISD_SHIFT = 1'b1
    } spisd_state_e;

    // one serial byte
    typedef logic [7:0] spisd_byte_t;

    // clock rate select field
    typedef logic [1:0] spisd_rate_t;

endpackage : spisd_pkg

// ### hdl/spisd_sync.sv
// two flip-flop synchroniser for the serial pins
`timescale 1ns/1ps
`default_nettype none

module spisd_sync #(
    parameter int WIDTH = 4
) (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clk_en,
    // asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    // refuse an empty synchroniser
    if (WIDTH < 1) begin : g_chk
        $error("spisd_sync: WIDTH must be at least 1");
    end

    // one pair of flops per pin; first flop feeds only the second
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta; // first stage, may go metastable
        always_ff @(posedge core_clk or posedge reset) begin
            if (reset) begin
                meta <= 1'b0;
                dout[i] <= 1'b0;
            end else if (clk_en) begin
                meta <= din[i];
                dout[i] <= meta;
            end
        end
    end

endmodule : spisd_sync

`default_nettype wire

// ### testbench/spisd_peer.sv
// far-side serial device: slave while the port is master, master while it is slave
`timescale 1ns/1ps
`default_nettype none

module spisd_peer (
    // resolved link lines
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    // lines the peer drives
    output logic sck_p,
    output logic mosi_p,
    output logic miso_p,
    output logic ss_n_p
);
    logic [7:0] slv = 8'h00; // byte answered as slave
    logic [7:0] rx = 8'h00; // byte heard as slave
    int nbits = 0; // slave bits heard since time zero

    // idle link: clock low, select high
    initial begin
        sck_p = 1'b0;
        mosi_p = 1'b0;
        ss_n_p = 1'b1;
    end

    // slave answer, msb first
    assign miso_p = slv[7];

    // slave sampling on the leading edge, only while not acting as master
    always @(posedge sck) begin
        if (ss_n_p) begin
            rx <= {rx[6:0], mosi};
            nbits <= nbits + 1;
        end
    end

    // slave shift on the trailing edge; spent bits become a changing pattern
    always @(negedge sck) begin
        if (ss_n_p) begin
            slv <= {slv[6:0], ~slv[7]};
        end
    end

    // preload the slave answer while the link is idle
    task load(input logic [7:0] b);
        slv = b;
    endtask : load

    // move the select line; offset keeps it clear of core clock edges
    task sel(input logic lvl);
        #37;
        ss_n_p = lvl;
        #400;
    endtask : sel

    // one master frame, phase 0 polarity 0, 800 ns serial period
    task xfer(input logic [7:0] tx, output logic [7:0] got);
        int i;
        #37;
        ss_n_p = 1'b0;
        mosi_p = tx[7];
        #400;
        for (i = 0; i < 8; i++) begin
            sck_p = 1'b1;
            got = {got[6:0], miso};
            #400;
            sck_p = 1'b0;
            mosi_p = (i < 7) ? tx[6-i] : ~tx[0]; // released line does not keep its value
            #400;
        end
        ss_n_p = 1'b1;
        #400;
    endtask : xfer
endmodule : spisd_peer
`default_nettype wire

// ### testbench/test_spi_status_and_data_path.sv
// self-checking bench for the serial port status flags and data path
`timescale 1ns/1ps
`default_nettype none
`include "spisd_defs.svh"

module test_spi_status_and_data_path;
    // clock, reset, bus
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1; // dropped for a while in the freeze scenario
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [3:0] wb_adr = 4'h0;
    logic [31:0] wb_dat_w = 32'h0;
    logic [3:0] wb_sel = 4'h1;
    logic [3:0] sel_v = 4'h1; // lanes used by the next request
    logic [31:0] wb_dat_r;
    logic wb_ack;
    // pin halves and interrupt
    logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, irq;
    logic sck_p, mosi_p, miso_p, ss_n_p;
    // each wire follows whoever enables it
    wire logic sck = sck_oe ? sck_out : sck_p;
    wire logic mosi = mosi_oe ? mosi_out : mosi_p;
    wire logic miso = miso_oe ? miso_out : miso_p;
    int fails = 0;
    int check_count = 0;
    logic [7:0] rd; // last byte read
    logic [7:0] got; // byte heard by the peer as master

    always #50 core_clk = ~core_clk;

    spisd_core #(.ADDR_W(4)) dut (
        .core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
        .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .sck_in(sck), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso), .miso_out(miso_out), .miso_oe(miso_oe),
        .ss_n(ss_n_p), .irq(irq));

    spisd_peer peer (
        .sck(sck), .mosi(mosi), .miso(miso),
        .sck_p(sck_p), .mosi_p(mosi_p), .miso_p(miso_p), .ss_n_p(ss_n_p));

    // compare and count
    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one classic cycle; holds everything until ack is sampled high
    task bus(input logic we, input logic [3:0] adr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge core_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= {24'h0, wd};
        wb_sel <= sel_v;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        if (n >= 50) check(8'h00, 8'h01); // no answer counts as a miss
        rd = wb_dat_r[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge core_clk); // idle cycle; with the next call's first wait, two idle cycles between requests
    endtask : bus

    // bounded wait for the interrupt level
    task wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wait_irq

    task test_reset();
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h00);
        bus(0, `SPISD_OFS_CTRL, 8'h00);
        check(rd, `SPISD_CTRL_RST);
        sel_v = 4'h2;
        bus(1, `SPISD_OFS_CTRL, 8'hff); // lane 0 off: write does nothing
        sel_v = 4'h1;
        bus(0, `SPISD_OFS_CTRL, 8'h00);
        check(rd, `SPISD_CTRL_RST);
        bus(1, 4'hc, 8'hff); // unmapped place swallows writes
        bus(0, 4'hc, 8'h00);
        check(rd, 8'h00);
        $display("test_reset finished");
    endtask : test_reset

    task test_master();
        peer.load(8'h3c);
        bus(1, `SPISD_OFS_CTRL, 8'hd2); // irq, enable, master, rate 2
        bus(1, `SPISD_OFS_DATA, 8'ha5);
        bus(1, `SPISD_OFS_DATA, 8'h5a); // colliding write mid-frame
        wait_irq();
        check({7'h0, irq}, 8'h01);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'hc0);
        check(peer.rx, 8'ha5);
        bus(0, `SPISD_OFS_DATA, 8'h00);
        check(rd, 8'h3c);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h00);
        check({7'h0, irq}, 8'h00);
        $display("test_master finished");
    endtask : test_master

    task test_lock();
        peer.load(8'he1);
        bus(1, `SPISD_OFS_DATA, 8'h0f);
        wait_irq();
        bus(1, `SPISD_OFS_DATA, 8'h77); // no status read yet: must be ignored
        repeat (40) @(posedge core_clk);
        check(peer.nbits[7:0], 8'h10);
        check(peer.rx, 8'h0f);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h80);
        bus(0, `SPISD_OFS_DATA, 8'h00);
        check(rd, 8'he1);
        $display("test_lock finished");
    endtask : test_lock

    task test_slave();
        bus(1, `SPISD_OFS_CTRL, 8'h40); // enabled slave, phase 0
        bus(1, `SPISD_OFS_DATA, 8'hc3);
        repeat (20) @(posedge core_clk);
        check({7'h0, sck_oe}, 8'h00);
        check(peer.nbits[7:0], 8'h10);
        peer.sel(1'b0);
        bus(1, `SPISD_OFS_DATA, 8'hff); // select low already counts as busy
        peer.xfer(8'h96, got);
        check(got, 8'hc3);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'hc0);
        peer.xfer(8'h69, got); // done still set: overrun
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'hc0);
        bus(0, `SPISD_OFS_DATA, 8'h00);
        check(rd, 8'h96);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h00);
        $display("test_slave finished");
    endtask : test_slave

    task test_fault();
        bus(1, `SPISD_OFS_CTRL, 8'hd2);
        peer.sel(1'b0); // second master pulls select low
        wait_irq();
        check({7'h0, irq}, 8'h01);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h10);
        bus(0, `SPISD_OFS_CTRL, 8'h00);
        check(rd, 8'h82);
        peer.sel(1'b1);
        bus(1, `SPISD_OFS_CTRL, 8'hd2); // restore within the clearing write
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h00);
        bus(0, `SPISD_OFS_CTRL, 8'h00);
        check(rd, 8'hd2);
        $display("test_fault finished");
    endtask : test_fault

    // frame frozen mid-way by the clock enable, then finished
    task test_freeze();
        peer.load(8'h81);
        bus(1, `SPISD_OFS_DATA, 8'h5a);
        repeat (10) @(posedge core_clk);
        clk_en <= 1'b0;
        repeat (200) @(posedge core_clk);
        check({7'h0, irq}, 8'h00);
        clk_en <= 1'b1;
        wait_irq();
        check({7'h0, irq}, 8'h01);
        check(peer.rx, 8'h5a);
        bus(0, `SPISD_OFS_STAT, 8'h00);
        check(rd, 8'h80);
        bus(0, `SPISD_OFS_DATA, 8'h00);
        check(rd, 8'h81);
        $display("test_freeze finished");
    endtask : test_freeze

    // single exit for normal end and watchdog
    task test_done();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // main sequence: two reset cycles, then every scenario
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        test_reset();
        test_master();
        test_lock();
        test_slave();
        test_fault();
        test_freeze();
        test_done();
    end

    // watchdog well beyond the expected hundred or so microseconds
    initial begin
        #2000000;
        fails = fails + 1;
        test_done();
    end
endmodule : test_spi_status_and_data_path
`default_nettype wire
